// *** rtl/atc_comparator.sv ***
// threshold comparator with delay filter and AXI4-Lite registers
//
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module atc_comparator #(
    parameter int unsigned TICK_CYCLES = atc_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // axi4-lite write address
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [7:0]                    s_axi_awaddr,
    // axi4-lite write data
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    // axi4-lite write response
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    output logic [1:0]                         s_axi_bresp,
    // axi4-lite read address
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    input  wire logic [7:0]                    s_axi_araddr,
    // axi4-lite read data
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    // measured values, one signed word per source code
    input  wire logic [atc_pkg::NUM_SRC-1:0][31:0] src_values,
    // comparator output to routing
    output logic                               cmp_out
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    atc_pkg::atc_cfg_type cfg_r;         // source, type, sign handling
    logic signed [31:0]   upper_r;       // upper_threshold as written
    logic signed [31:0]   lower_r;       // lower_threshold as written
    logic [15:0]          adly_r;        // assert_delay
    logic [15:0]          ddly_r;        // deassert_delay
    logic                 raw_r;         // undelayed comparator state
    logic                 out_r;         // delayed output
    logic [15:0]          timer_r;       // delay_timer_value
    logic                 tick;          // one-second enable

    // ------------------------------------------------------------
    // bus slave state
    // ------------------------------------------------------------
    logic        aw_full_r, w_full_r;    // write address, write data held
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0]  wstrb_r;
    logic        bvalid_r, rvalid_r;
    logic [1:0]  bresp_r, rresp_r;
    logic [31:0] rd_word;                // read mux before the data register
    logic        do_wr, wr_ok, rd_ok;    // both halves in, writable, mapped read
    atc_sec_tick #(.CYCLES (TICK_CYCLES)) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick)
    );
    // ------------------------------------------------------------
    // range limits and monitored value
    // ------------------------------------------------------------
    logic signed [31:0] max_lim, min_lim;        // top and bottom of the source range
    logic signed [31:0] upper_eff, lower_eff;    // clamped thresholds
    logic signed [31:0] sample, mon;             // selected source word, monitored value
    logic               in_band;                 // lower <= monitored <= upper
    logic [15:0]        adly_eff, ddly_eff;      // delays limited to the maximum
    logic [15:0]        dly_sel;                 // delay for the pending change
    // saturate a threshold into the source range
    function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                                 input logic signed [31:0] lo,
                                                 input logic signed [31:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction
    // limits follow the current source, so changing source re-clamps
    always_comb
    begin
        max_lim = atc_pkg::SRC_MAX[cfg_r.src];
        if (cfg_r.sign == atc_pkg::SIGNED)
            min_lim = -max_lim;
        else if (atc_pkg::PROBE_SRC[cfg_r.src])
            min_lim = atc_pkg::PROBE_MIN;
        else
            min_lim = '0;
        upper_eff = clamp(upper_r, min_lim, max_lim);
        lower_eff = clamp(lower_r, min_lim, max_lim);
    end

    // magnitude or signed view of the source
    always_comb
    begin
        sample = $signed(src_values[cfg_r.src]);
        if (cfg_r.sign == atc_pkg::SIGNED)
            mon = sample;
        else if (sample < 0)
            mon = -sample;
        else
            mon = sample;
        in_band = (mon >= lower_eff) && (mon <= upper_eff);
    end

    // ------------------------------------------------------------
    // raw comparator
    // ------------------------------------------------------------
    // one register stage so the filter sees a clean level
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            raw_r <= 1'b0;
        else if (cfg_r.kind == atc_pkg::WINDOW)
            raw_r <= in_band;
        else if (mon >= upper_eff)
            raw_r <= 1'b1;
        else if (mon < lower_eff && lower_eff <= upper_eff)
            raw_r <= 1'b0;
        // between levels the state holds
    end

    // ------------------------------------------------------------
    // delay filter
    // ------------------------------------------------------------
    assign adly_eff = (adly_r > atc_pkg::DLY_MAX) ? atc_pkg::DLY_MAX : adly_r;
    assign ddly_eff = (ddly_r > atc_pkg::DLY_MAX) ? atc_pkg::DLY_MAX : ddly_r;
    assign dly_sel  = raw_r ? adly_eff : ddly_eff;

    // a bounce back to the output level clears the timer, so a change
    // must persist for the whole delay; zero delay passes in one cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            out_r   <= 1'b0;
            timer_r <= '0;
        end
        else if (raw_r == out_r)
            timer_r <= '0;
        else if (timer_r >= dly_sel)
        begin
            out_r   <= raw_r;
            timer_r <= '0;
        end
        else if (tick)
            timer_r <= timer_r + 16'h0001;
    end

    assign cmp_out = out_r;

    // ------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_full_r && !bvalid_r;
    assign s_axi_wready  = !w_full_r && !bvalid_r;
    assign do_wr         = aw_full_r && w_full_r && !bvalid_r;
    assign wr_ok         = awaddr_r[1:0] == 2'h0 && (awaddr_r <= atc_pkg::OFS_DDLY);

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  be);
        logic [31:0] r;
        for (int i = 0; i < 4; i++)
            r[8*i +: 8] = be[i] ? d[8*i +: 8] : old[8*i +: 8];
        return r;
    endfunction

    // address and data are caught independently, in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= '0;
            wstrb_r   <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            else if (do_wr)
                aw_full_r <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            else if (do_wr)
                w_full_r <= 1'b0;
        end
    end

    // response one cycle after both halves are in
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r  <= 2'h0;
        end
        else if (do_wr)
        begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_ok ? 2'h0 : 2'h2;   // slverr for status, timer or unmapped
        end
        else if (s_axi_bready)
            bvalid_r <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // an out-of-range source code is dropped so the mux never aliases
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_r.src  <= atc_pkg::SRC_SPEED;
            cfg_r.kind <= atc_pkg::HYSTERESIS;
            cfg_r.sign <= atc_pkg::MAGNITUDE;
            upper_r    <= atc_pkg::UPPER_RST;
            lower_r    <= atc_pkg::LOWER_RST;
            adly_r     <= atc_pkg::DLY_RST;
            ddly_r     <= atc_pkg::DLY_RST;
        end
        else if (do_wr)
        begin
            unique case (awaddr_r)
                atc_pkg::OFS_CTRL:
                begin
                    if (wstrb_r[0] && wdata_r[4:0] <= atc_pkg::SRC_LAST)
                        cfg_r.src <= wdata_r[atc_pkg::CTRL_SRC_LSB +: 5];
                    if (wstrb_r[1])
                    begin
                        cfg_r.kind <= atc_pkg::atc_kind_type'(wdata_r[atc_pkg::CTRL_TYPE]);
                        cfg_r.sign <= atc_pkg::atc_sign_type'(wdata_r[atc_pkg::CTRL_SIGN]);
                    end
                end
                atc_pkg::OFS_UPPER: upper_r <= merge(upper_r, wdata_r, wstrb_r);
                atc_pkg::OFS_LOWER: lower_r <= merge(lower_r, wdata_r, wstrb_r);
                atc_pkg::OFS_ADLY:  adly_r  <= 16'(merge({16'h0, adly_r}, wdata_r, wstrb_r));
                atc_pkg::OFS_DDLY:  ddly_r  <= 16'(merge({16'h0, ddly_r}, wdata_r, wstrb_r));
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------
    // thresholds and delays read back as the values in force
    always_comb
    begin
        rd_ok = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= atc_pkg::OFS_TIMER);
        unique case (s_axi_araddr)
            atc_pkg::OFS_CTRL:   rd_word = {22'h0, cfg_r.sign, cfg_r.kind, 3'h0, cfg_r.src};
            atc_pkg::OFS_UPPER:  rd_word = upper_eff;
            atc_pkg::OFS_LOWER:  rd_word = lower_eff;
            atc_pkg::OFS_ADLY:   rd_word = {16'h0, adly_eff};
            atc_pkg::OFS_DDLY:   rd_word = {16'h0, ddly_eff};
            atc_pkg::OFS_STATUS: rd_word = {30'h0, raw_r, out_r};
            atc_pkg::OFS_TIMER:  rd_word = {16'h0, timer_r};
            default:             rd_word = 32'h0;
        endcase
    end

    assign s_axi_arready = !rvalid_r;

    // data registered on the address handshake, held until rready
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= 2'h0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_ok ? 2'h0 : 2'h2;
        end
        else if (s_axi_rready)
            rvalid_r <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    hyst_set_a: assert property (cfg_r.kind == atc_pkg::HYSTERESIS && mon >= upper_eff
        |=> raw_r) else $error("hysteresis did not set above upper");
    hyst_low_a: assert property (cfg_r.kind == atc_pkg::HYSTERESIS && !raw_r
        && mon < upper_eff |=> !raw_r) else $error("hysteresis set below upper");
    hyst_keep_a: assert property (cfg_r.kind == atc_pkg::HYSTERESIS && raw_r
        && mon >= lower_eff |=> raw_r) else $error("hysteresis cleared above lower");
    hyst_clr_a: assert property (cfg_r.kind == atc_pkg::HYSTERESIS && mon < lower_eff
        && lower_eff <= upper_eff |=> !raw_r) else $error("hysteresis did not clear below lower");
    latch_hold_a: assert property (cfg_r.kind == atc_pkg::HYSTERESIS && raw_r
        && lower_eff > upper_eff |=> raw_r) else $error("latched output cleared");
    win_in_a: assert property (cfg_r.kind == atc_pkg::WINDOW && in_band
        |=> raw_r) else $error("window not set inside band");
    win_below_a: assert property (cfg_r.kind == atc_pkg::WINDOW && mon < lower_eff
        |=> !raw_r) else $error("window set below band");
    win_above_a: assert property (cfg_r.kind == atc_pkg::WINDOW && mon > upper_eff
        |=> !raw_r) else $error("window set above band");
    thr_range_a: assert property (upper_eff <= max_lim && lower_eff >= min_lim
        && lower_eff <= max_lim) else $error("threshold outside source range");
    out_rise_a: assert property ($rose(out_r) |-> $past(timer_r) >= $past(adly_eff))
        else $error("output rose before assert delay");
    out_fall_a: assert property ($fell(out_r) |-> $past(timer_r) >= $past(ddly_eff))
        else $error("output fell before deassert delay");
    zero_dly_a: assert property (raw_r != out_r && dly_sel == 16'h0 ##1 raw_r == $past(raw_r)
        |-> out_r == raw_r) else $error("zero delay did not pass at once");
    timer_max_a: assert property (timer_r <= atc_pkg::DLY_MAX)
        else $error("timer beyond range");
    timer_clr_a: assert property (raw_r == out_r |=> timer_r == 16'h0)
        else $error("timer not restarted");
    src_range_a: assert property (cfg_r.src <= atc_pkg::SRC_LAST)
        else $error("source code out of range");

    hyst_cycle_c: cover property (cfg_r.kind == atc_pkg::HYSTERESIS && $rose(out_r));
    win_exit_c:   cover property (cfg_r.kind == atc_pkg::WINDOW && $fell(out_r));
    delayed_c:    cover property ($rose(out_r) && adly_eff != 16'h0);
    bounce_c:     cover property (timer_r != 16'h0 ##1 raw_r == out_r);
endmodule

// *** rtl/atc_pkg.sv ***
// package: register map, reset values and limits of the threshold comparator
package atc_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00; // source, type, sign handling
    localparam logic [7:0] OFS_UPPER  = 8'h04; // upper_threshold
    localparam logic [7:0] OFS_LOWER  = 8'h08; // lower_threshold
    localparam logic [7:0] OFS_ADLY   = 8'h0c; // assert_delay, seconds
    localparam logic [7:0] OFS_DDLY   = 8'h10; // deassert_delay, seconds
    localparam logic [7:0] OFS_STATUS = 8'h14; // output and raw condition
    localparam logic [7:0] OFS_TIMER  = 8'h18; // delay_timer_value, seconds

    // ------------------------------------------------------------
    // ctrl field positions
    // ------------------------------------------------------------
    localparam int CTRL_SRC_LSB = 0;  // 5-bit source code
    localparam int CTRL_TYPE    = 8;  // 0 hysteresis, 1 window
    localparam int CTRL_SIGN    = 9;  // 0 magnitude, 1 signed

    // ------------------------------------------------------------
    // values after reset and ranges
    // ------------------------------------------------------------
    localparam logic [4:0]         SRC_SPEED   = 5'h01; // default source
    localparam logic [4:0]         SRC_LAST    = 5'h1a; // highest source code, 26
    localparam int                 NUM_SRC     = 27;
    localparam logic signed [31:0] UPPER_RST   = 32'sh0000012c; // 300 rpm
    localparam logic signed [31:0] LOWER_RST   = 32'sh000000c8; // 200 rpm
    localparam logic [15:0]        DLY_RST     = 16'h0000;
    localparam logic [15:0]        DLY_MAX     = 16'h8ca0;      // 36000 s

    // ------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 50_000_000; // aclk rate
    localparam int unsigned TICK_S      = 1;          // timer step, seconds
    localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;

    // ------------------------------------------------------------
    // per-source limits; motor/process dependent entries are plain defaults
    // ------------------------------------------------------------
    localparam logic signed [31:0] SRC_MAX [NUM_SRC] = '{
        32'sh000f4240, 32'sh000005dc, 32'sh00000190, 32'sh00000190,
        32'sh00000190, 32'sh00000190, 32'sh000003e8, 32'sh00000190,
        32'sh000004e2, 32'sh00000064, 32'sh0000012c, 32'sh0000012c,
        32'sh0000012c, 32'sh000f4240, 32'sh0000ffff, 32'sh0000ffff,
        32'sh00000064, 32'sh00000064, 32'sh00000064, 32'sh00000064,
        32'sh000f4240, 32'sh000f4240, 32'sh0000012c, 32'sh0000012c,
        32'sh0000012c, 32'sh00000064, 32'sh00000064};
    localparam logic signed [31:0] PROBE_MIN = 32'shffffff9c; // -100 degC
    localparam logic [NUM_SRC-1:0] PROBE_SRC = 27'h1c01c00;   // codes 10-12, 22-24

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef enum logic { HYSTERESIS, WINDOW } atc_kind_type;
    typedef enum logic { MAGNITUDE, SIGNED } atc_sign_type;
    typedef struct packed {
        logic [4:0]   src;
        atc_kind_type kind;
        atc_sign_type sign;
    } atc_cfg_type;
endpackage

// *** rtl/atc_sec_tick.sv ***
// one-cycle enable pulse once per timer step
`timescale 1ns/1ps
module atc_sec_tick #(
    parameter int unsigned CYCLES = 50_000_000
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // pulse out
    output logic      tick
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt_r; // cycles within the current step

    // free-running divider; tick on the last cycle of each step
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_r <= '0;
        else if (cnt_r == LAST)
            cnt_r <= '0;
        else
            cnt_r <= cnt_r + W'(1);
    end

    assign tick = (cnt_r == LAST);
endmodule

// *** tb/atc_src_model.sv ***
// model of the measured-value sources that feed the comparator
`timescale 1ns/1ps
module atc_src_model (
    // clock
    input  wire logic                          aclk,
    // value placed on the chosen source
    input  wire logic [4:0]                    sel,
    input  wire logic [31:0]                   val,
    // measured values toward the comparator
    output logic [atc_pkg::NUM_SRC-1:0][31:0]  src_values
);
    // ------------------------------------------------------------
    // one new sample per clock
    // ------------------------------------------------------------
    logic flip_r = 1'b0; // alternates each cycle
    // unused sources toggle every cycle, so reading the wrong one shows up
    always @(posedge aclk)
    begin
        flip_r <= ~flip_r;
        for (int i = 0; i < atc_pkg::NUM_SRC; i++)
            src_values[i] <= (i == int'(sel)) ? val : {32{flip_r}};
    end
endmodule

// *** tb/analog_threshold_comparator_tb.sv ***
// self-checking bench for the threshold comparator over its register bus
`timescale 1ns/1ps
module analog_threshold_comparator_tb;
    // clock, reset, bus and stimulus
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic        cmp_out;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, val = 32'h0;
    logic [1:0]  bresp, rresp;
    logic [atc_pkg::NUM_SRC-1:0][31:0] src_values;
    int          n_mismatch = 0, total_checks = 0, cyc = 0;

    // short tick so delays of a few seconds stay cheap
    atc_comparator #(.TICK_CYCLES(10)) u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .src_values(src_values), .cmp_out(cmp_out));
    atc_src_model u_src (.aclk(aclk), .sel(atc_pkg::SRC_SPEED), .val(val), .src_values(src_values));

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        {awvalid, wvalid, bready} <= 3'b111;
        awaddr <= a;
        wdata <= d;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
    endtask
    // a nonzero top turns the data compare into a range exp..top
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er,
                      input logic [31:0] top = 32'h0);
        @(posedge aclk);
        {arvalid, rready} <= 2'b11;
        araddr <= a;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        if (top == 32'h0)
            chk("rdata", exp, rdata);
        else if ((rdata >= exp && rdata <= top) !== 1'b1)
            chk("rdata", exp, rdata);
        else
            total_checks++;
        chk("rresp", 32'(er), 32'(rresp));
    endtask
    // new measured value, then the output once the pipeline has settled
    task automatic sv(input logic [31:0] v, input logic e);
        @(posedge aclk);
        val <= v;
        repeat (5) @(posedge aclk);
        chk("cmp_out", 32'(e), 32'(cmp_out));
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // clock and a hang guard well above the few hundred cycles needed
    always #10 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_mismatch++;
            print_verdict;
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00, 32'h1, 2'h0);
        rd(8'h04, atc_pkg::UPPER_RST, 2'h0);
        rd(8'h08, atc_pkg::LOWER_RST, 2'h0);
        rd(8'h18, 32'h0, 2'h0);
        rd(8'h1c, 32'h0, 2'h2);
        wr(8'h14, 32'h1, 2'h2);
        sv(32'hfa, 1'b0);
        sv(32'h12c, 1'b1);
        sv(32'hfa, 1'b1);
        sv(32'hc7, 1'b0);
        sv(32'hfffffea2, 1'b1);
        wr(8'h00, 32'h201, 2'h0);
        sv(32'hfffffea2, 1'b0);
        wr(8'h08, 32'hfffffe0c, 2'h0);
        rd(8'h08, 32'hfffffe0c, 2'h0);
        wr(8'h00, 32'h1, 2'h0);
        rd(8'h08, 32'h0, 2'h0);
        wr(8'h04, 32'h7d0, 2'h0);
        rd(8'h04, 32'h5dc, 2'h0);
        wr(8'h00, 32'h10, 2'h0);
        rd(8'h04, 32'h64, 2'h0);
        wr(8'h00, 32'ha, 2'h0);
        rd(8'h08, 32'hffffff9c, 2'h0);
        wr(8'h00, 32'h11b, 2'h0);
        rd(8'h00, 32'h10a, 2'h0);
        wr(8'h00, 32'h101, 2'h0);
        wr(8'h04, 32'h12c, 2'h0);
        wr(8'h08, 32'hc8, 2'h0);
        sv(32'h64, 1'b0);
        sv(32'hfa, 1'b1);
        sv(32'h15e, 1'b0);
        sv(32'h12c, 1'b1);
        sv(32'hc7, 1'b0);
        wr(8'h00, 32'h1, 2'h0);
        wr(8'h08, 32'h190, 2'h0);
        sv(32'h15e, 1'b1);
        sv(32'h0, 1'b1);
        wr(8'h08, 32'hc8, 2'h0);
        sv(32'h0, 1'b0);
        wr(8'h0c, 32'h3, 2'h0);
        wr(8'h10, 32'h2, 2'h0);
        sv(32'h15e, 1'b0);
        repeat (10) @(posedge aclk);
        chk("cmp_out", 32'h0, 32'(cmp_out));
        rd(8'h18, 32'h1, 2'h0, 32'h2);
        repeat (20) @(posedge aclk);
        chk("cmp_out", 32'h1, 32'(cmp_out));
        rd(8'h14, 32'h3, 2'h0);
        rd(8'h18, 32'h0, 2'h0);
        sv(32'h64, 1'b1);
        sv(32'h15e, 1'b1);
        sv(32'h64, 1'b1);
        repeat (4) @(posedge aclk);
        chk("cmp_out", 32'h1, 32'(cmp_out));
        repeat (20) @(posedge aclk);
        chk("cmp_out", 32'h0, 32'(cmp_out));
        print_verdict;
    end
endmodule
